// File: logic/power_mode_clock_switch.sv
// Clock source sequencer for run, idle and deep-sleep modes with AXI4-Lite registers
// Notes on behaviour
// [RQ1] - Switch waits start-up plus old and new ticks
// [RQ2] - Three flags encode the active main clock
// [RQ3] - Sleep request samples idle select bit
// [RQ4] - Sleep with idle clear stops all clocks
// [RQ5] - Idle sleep keeps peripherals clocked, core gated
// [RQ6] - Run modes clock both core and peripherals
// [RQ7] - Reset enters primary run, primary flag set
// [RQ8] - Internal primary sets HF stable flag too
// [RQ9] - Select 01 enters secondary run mode
// [RQ10] - Leaving secondary keeps old clock until ready
// [RQ11] - Timer oscillator runs while its enable set
// [RQ12] - Secondary entry deferred until enabled and ready
// [RQ13] - Upper select bit set means internal run
// [RQ14] - Internal switch stops primary, clears its flag
// [RQ15] - Frequency select applies immediately on write
// [RQ16] - Leaving internal keeps internal clock until ready
// [RQ17] - Internal primary still pays switch delay
// [RQ18] - Deep sleep stops oscillator, clears all flags
// [RQ19] - Idle select bit clears at reset
// [RQ20] - Deep sleep keeps watchdog and timer oscillators
// [RQ21] - Wake withholds clocks until source ready, except two-speed or fail-safe clocks from internal meanwhile
// [RQ22] - Wake leaves idle and select bits alone
// [RQ23] - Select decodes 00 primary, 01 secondary, 1x internal
// [RQ24] - Handover never emits a runt clock pulse
`timescale 1ns/1ps
module power_mode_clock_switch (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Oscillator pins: ticks and ready, index 0 primary, 1 secondary, 2 internal
   input wire logic [2:0] i_osc_tick,
   input wire logic [2:0] i_osc_ready,
   input wire pm_clock_pkg::cfg_t i_cfg,
   // CPU side
   input wire logic i_sleep_req,
   input wire logic i_wake,
   // Gated clock enables and oscillator controls
   output logic o_core_clk_en,
   output logic o_periph_clk_en,
   output pm_clock_pkg::osc_en_t o_osc_en,
   output pm_clock_pkg::flags_t o_flags,
   output logic [2:0] o_int_freq,
   // AXI4-Lite slave
   input wire logic [pm_clock_pkg::AXI_AW-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [pm_clock_pkg::AXI_AW-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   function automatic logic pick(input pm_clock_pkg::src_t s, input logic [2:0] v);
      pick = v[s];
   endfunction

   function automatic pm_clock_pkg::src_t decode_sel(input logic [1:0] sel);
      if (sel[1]) begin // [RQ13] [RQ23]
         decode_sel = pm_clock_pkg::SRC_INT;
      end else if (sel[0]) begin
         decode_sel = pm_clock_pkg::SRC_SEC;
      end else begin
         decode_sel = pm_clock_pkg::SRC_PRI;
      end
   endfunction

   logic [1:0] rst_pipe;
   logic rst_n;
   logic [9:0] sync1;
   logic [9:0] sync2;
   logic [2:0] tick_d;
   logic [2:0] tick;
   logic [2:0] rdy;
   pm_clock_pkg::cfg_t cfg;

   // Reset release through two flops
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'h1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Oscillator pins are asynchronous; only sync2 feeds logic
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 10'h000;
         sync2 <= 10'h000;
         tick_d <= 3'h0;
      end else begin
         sync1 <= {i_osc_tick, i_osc_ready, i_cfg};
         sync2 <= sync1;
         tick_d <= sync2[9:7];
      end
   end
   assign tick = sync2[9:7] & ~tick_d;
   assign cfg = sync2[3:0];

   // Register fields
   logic idle_select_bit, next_idle_select_bit;
   logic [2:0] freq, next_freq;
   logic [1:0] clock_source_select, next_clock_source_select;
   logic secondary_osc_enable, next_secondary_osc_enable;
   // AXI state
   logic aw_hold, next_aw_hold;
   logic [pm_clock_pkg::AXI_AW-1:0] awaddr_q, next_awaddr_q;
   logic w_hold, next_w_hold;
   logic [31:0] wdata_q, next_wdata_q;
   logic wstrb0_q, next_wstrb0_q;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_fire;

   // Mode state
   pm_clock_pkg::mode_t mode, next_mode;
   pm_clock_pkg::src_t src, next_src, tgt, next_tgt, want;
   pm_clock_pkg::phase_t phase, next_phase;
   logic [1:0] cnt, next_cnt;
   logic next_core, next_periph;
   pm_clock_pkg::osc_en_t next_osc;
   pm_clock_pkg::flags_t next_flags;
   logic src_tick, tgt_tick, tgt_rdy, boost;

   // Internal source counts ready at once when running from the always-on low range
   assign rdy = {sync2[6] | (freq == 3'h0), sync2[5] & secondary_osc_enable, sync2[4]};
   assign src_tick = pick(src, tick);
   assign tgt_tick = pick(tgt, tick);
   assign tgt_rdy = pick(tgt, rdy);
   assign want = decode_sel(clock_source_select);
   assign boost = cfg.two_speed | cfg.fail_safe;

   always_comb begin
      next_idle_select_bit = idle_select_bit; // [RQ22]
      next_freq = freq;
      next_clock_source_select = clock_source_select;
      next_secondary_osc_enable = secondary_osc_enable;
      next_aw_hold = aw_hold;
      next_awaddr_q = awaddr_q;
      next_w_hold = w_hold;
      next_wdata_q = wdata_q;
      next_wstrb0_q = wstrb0_q;
      next_bvalid = o_bvalid;
      next_bresp = o_bresp;
      next_rvalid = o_rvalid;
      next_rdata = o_rdata;
      next_rresp = o_rresp;
      wr_fire = 1'h0;
      if (i_awvalid && o_awready) begin
         next_aw_hold = 1'h1;
         next_awaddr_q = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         next_w_hold = 1'h1;
         next_wdata_q = i_wdata;
         next_wstrb0_q = i_wstrb[0];
      end
      if (o_bvalid && i_bready) begin
         next_bvalid = 1'h0;
      end
      if (aw_hold && w_hold && !o_bvalid) begin
         wr_fire = 1'h1;
         next_aw_hold = 1'h0;
         next_w_hold = 1'h0;
         next_bvalid = 1'h1;
         next_bresp = pm_clock_pkg::RESP_OKAY;
         if (awaddr_q == pm_clock_pkg::ADDR_CTRL) begin
            if (wstrb0_q) begin
               next_idle_select_bit = wdata_q[pm_clock_pkg::CTRL_IDLE_BIT];
               next_freq = wdata_q[pm_clock_pkg::CTRL_FREQ_LSB +: 3]; // [RQ15]
               next_clock_source_select = wdata_q[pm_clock_pkg::CTRL_SEL_LSB +: 2];
            end
         end else if (awaddr_q == pm_clock_pkg::ADDR_SECT) begin
            if (wstrb0_q) begin
               next_secondary_osc_enable = wdata_q[pm_clock_pkg::SECT_EN_BIT];
            end
         end else if (awaddr_q != pm_clock_pkg::ADDR_STAT) begin
            next_bresp = pm_clock_pkg::RESP_SLVERR;
         end
      end
      if (o_rvalid && i_rready) begin
         next_rvalid = 1'h0;
      end
      if (i_arvalid && o_arready) begin
         next_rvalid = 1'h1;
         next_rdata = 32'h0000_0000;
         next_rresp = pm_clock_pkg::RESP_OKAY;
         if (i_araddr == pm_clock_pkg::ADDR_CTRL) begin
            next_rdata[pm_clock_pkg::CTRL_IDLE_BIT] = idle_select_bit;
            next_rdata[pm_clock_pkg::CTRL_FREQ_LSB +: 3] = freq;
            next_rdata[pm_clock_pkg::CTRL_PRI_BIT] = o_flags.primary_running_flag;
            next_rdata[pm_clock_pkg::CTRL_HF_BIT] = o_flags.internal_hf_stable_flag;
            next_rdata[pm_clock_pkg::CTRL_SEL_LSB +: 2] = clock_source_select;
         end else if (i_araddr == pm_clock_pkg::ADDR_SECT) begin
            next_rdata[pm_clock_pkg::SECT_EN_BIT] = secondary_osc_enable;
            next_rdata[pm_clock_pkg::SECT_RUN_BIT] = o_flags.secondary_active_flag;
         end else if (i_araddr == pm_clock_pkg::ADDR_STAT) begin
            next_rdata[pm_clock_pkg::STAT_FLAGS_LSB +: 3] = o_flags;
            next_rdata[pm_clock_pkg::STAT_MODE_LSB +: 3] = mode;
            next_rdata[pm_clock_pkg::STAT_SRC_LSB +: 2] = src;
         end else begin
            next_rresp = pm_clock_pkg::RESP_SLVERR;
         end
      end
      // One write and one read at a time; a pending response blocks new requests
      next_awready = !next_aw_hold && !next_bvalid;
      next_wready = !next_w_hold && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_select_bit <= pm_clock_pkg::RST_IDLE; // [RQ19]
         freq <= pm_clock_pkg::RST_FREQ;
         clock_source_select <= pm_clock_pkg::RST_SEL;
         secondary_osc_enable <= pm_clock_pkg::RST_SEC_EN;
         aw_hold <= 1'h0;
         awaddr_q <= 4'h0;
         w_hold <= 1'h0;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'h0;
         o_awready <= 1'h0;
         o_wready <= 1'h0;
         o_bvalid <= 1'h0;
         o_bresp <= pm_clock_pkg::RESP_OKAY;
         o_arready <= 1'h0;
         o_rvalid <= 1'h0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= pm_clock_pkg::RESP_OKAY;
      end else begin
         idle_select_bit <= next_idle_select_bit;
         freq <= next_freq;
         clock_source_select <= next_clock_source_select;
         secondary_osc_enable <= next_secondary_osc_enable;
         aw_hold <= next_aw_hold;
         awaddr_q <= next_awaddr_q;
         w_hold <= next_w_hold;
         wdata_q <= next_wdata_q;
         wstrb0_q <= next_wstrb0_q;
         o_awready <= next_awready;
         o_wready <= next_wready;
         o_bvalid <= next_bvalid;
         o_bresp <= next_bresp;
         o_arready <= next_arready;
         o_rvalid <= next_rvalid;
         o_rdata <= next_rdata;
         o_rresp <= next_rresp;
      end
   end
   assign o_int_freq = freq; // [RQ15]

   always_comb begin
      next_mode = mode;
      next_src = src;
      next_tgt = tgt;
      next_phase = phase;
      next_cnt = cnt;
      case (mode)
         pm_clock_pkg::M_RUN: begin
            if (i_sleep_req) begin
               next_mode = idle_select_bit ? pm_clock_pkg::M_IDLE : pm_clock_pkg::M_SLEEP; // [RQ3]
            end else if (want != src && (want != pm_clock_pkg::SRC_SEC || secondary_osc_enable)) begin // [RQ12]
               next_mode = pm_clock_pkg::M_SWITCH; // [RQ17]
               next_tgt = want;
               next_phase = pm_clock_pkg::P_START;
               next_cnt = 2'h0;
            end
         end
         pm_clock_pkg::M_SWITCH: begin
            case (phase)
               pm_clock_pkg::P_START: begin
                  // Old source keeps clocking while the new one starts
                  if (want != tgt) begin
                     next_mode = pm_clock_pkg::M_RUN;
                  end else if (tgt_rdy) begin // [RQ10] [RQ16]
                     next_phase = pm_clock_pkg::P_OLD;
                  end
               end
               pm_clock_pkg::P_OLD: begin
                  if (src_tick) begin // [RQ1]
                     next_cnt = cnt + 2'h1;
                     if (cnt == pm_clock_pkg::OLD_TICKS - 2'h1) begin
                        next_phase = pm_clock_pkg::P_NEW;
                        next_cnt = 2'h0;
                     end
                  end
               end
               default: begin
                  if (tgt_tick) begin // [RQ1]
                     next_cnt = cnt + 2'h1;
                     if (cnt == pm_clock_pkg::NEW_TICKS - 2'h1) begin
                        next_mode = pm_clock_pkg::M_RUN;
                        next_src = tgt; // [RQ9] [RQ14]
                        next_cnt = 2'h0;
                     end
                  end
               end
            endcase
         end
         pm_clock_pkg::M_IDLE: begin
            if (i_wake) begin
               next_mode = pm_clock_pkg::M_RUN;
            end
         end
         pm_clock_pkg::M_SLEEP: begin
            if (i_wake) begin
               next_mode = pm_clock_pkg::M_WAKE;
               next_src = (want == pm_clock_pkg::SRC_SEC && !secondary_osc_enable) ? src : want;
            end
         end
         default: begin
            if (pick(src, rdy)) begin // [RQ21]
               next_mode = pm_clock_pkg::M_RUN;
            end
         end
      endcase

      // Enables are whole source ticks, so a handover cannot shorten a phase
      next_core = 1'h0;
      next_periph = 1'h0;
      if (mode == pm_clock_pkg::M_RUN || (mode == pm_clock_pkg::M_SWITCH && phase == pm_clock_pkg::P_START)) begin
         next_core = src_tick && !(mode == pm_clock_pkg::M_RUN && i_sleep_req); // [RQ6] [RQ24]
         next_periph = src_tick && !(mode == pm_clock_pkg::M_RUN && i_sleep_req && !idle_select_bit); // [RQ4]
      end else if (mode == pm_clock_pkg::M_IDLE) begin
         next_periph = src_tick; // [RQ5]
      end else if (mode == pm_clock_pkg::M_WAKE && boost) begin
         next_core = tick[2]; // [RQ21]
         next_periph = tick[2];
      end

      next_flags = 3'h0; // [RQ18]
      if (next_mode != pm_clock_pkg::M_SLEEP && next_mode != pm_clock_pkg::M_WAKE) begin
         next_flags.primary_running_flag = (next_src == pm_clock_pkg::SRC_PRI); // [RQ2] [RQ7]
         next_flags.internal_hf_stable_flag = sync2[6] && ((next_src == pm_clock_pkg::SRC_INT && freq != 3'h0)
            || (next_src == pm_clock_pkg::SRC_PRI && cfg.pri_is_internal)); // [RQ8]
         next_flags.secondary_active_flag = (next_src == pm_clock_pkg::SRC_SEC); // [RQ9]
      end

      next_osc.sec = secondary_osc_enable; // [RQ11] [RQ20]
      next_osc.pri = 1'h0;
      next_osc.hf = 1'h0;
      next_osc.lf = cfg.wdt_on || cfg.fail_safe; // [RQ20]
      if (next_mode != pm_clock_pkg::M_SLEEP) begin
         next_osc.pri = (next_src == pm_clock_pkg::SRC_PRI)
            || (next_mode == pm_clock_pkg::M_SWITCH && next_tgt == pm_clock_pkg::SRC_PRI); // [RQ14]
         next_osc.hf = (next_src == pm_clock_pkg::SRC_PRI && cfg.pri_is_internal)
            || (next_mode == pm_clock_pkg::M_WAKE && boost)
            || (freq != 3'h0 && (next_src == pm_clock_pkg::SRC_INT
            || (next_mode == pm_clock_pkg::M_SWITCH && next_tgt == pm_clock_pkg::SRC_INT)));
         next_osc.lf = next_osc.lf || (freq == 3'h0 && (next_src == pm_clock_pkg::SRC_INT
            || (next_mode == pm_clock_pkg::M_SWITCH && next_tgt == pm_clock_pkg::SRC_INT)));
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= pm_clock_pkg::M_RUN; // [RQ7]
         src <= pm_clock_pkg::SRC_PRI;
         tgt <= pm_clock_pkg::SRC_PRI;
         phase <= pm_clock_pkg::P_START;
         cnt <= 2'h0;
         o_core_clk_en <= 1'h0;
         o_periph_clk_en <= 1'h0;
         o_flags <= 3'h4;
         o_osc_en <= 4'h8;
      end else begin
         mode <= next_mode;
         src <= next_src;
         tgt <= next_tgt;
         phase <= next_phase;
         cnt <= next_cnt;
         o_core_clk_en <= next_core;
         o_periph_clk_en <= next_periph;
         o_flags <= next_flags;
         o_osc_en <= next_osc;
      end
   end

   sleep_entry_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ4]
      (mode == pm_clock_pkg::M_RUN && i_sleep_req && !idle_select_bit)
      |=> (mode == pm_clock_pkg::M_SLEEP && !o_core_clk_en && !o_periph_clk_en))
      else $error("sleep entry did not stop clocks");
   idle_entry_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ5]
      (mode == pm_clock_pkg::M_IDLE && src_tick) |=> (o_periph_clk_en && !o_core_clk_en))
      else $error("idle mode clocking wrong");
   run_clocks_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ6]
      (mode == pm_clock_pkg::M_RUN && src_tick && !i_sleep_req) |=> (o_core_clk_en && o_periph_clk_en))
      else $error("run mode tick not passed");
   handover_gap_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ24]
      (mode == pm_clock_pkg::M_SWITCH && phase != pm_clock_pkg::P_START) |=> !o_core_clk_en)
      else $error("clock pulse during handover");
   switch_done_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ1]
      (mode == pm_clock_pkg::M_SWITCH && phase == pm_clock_pkg::P_NEW && tgt_tick
      && cnt == pm_clock_pkg::NEW_TICKS - 2'h1) |=> (mode == pm_clock_pkg::M_RUN && src == $past(tgt)))
      else $error("switch did not complete");
   sec_flags_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ9]
      (mode == pm_clock_pkg::M_RUN && src == pm_clock_pkg::SRC_SEC) |-> (o_flags == 3'h1 && !o_osc_en.pri))
      else $error("secondary run flags wrong");
   pri_flag_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ7]
      (mode == pm_clock_pkg::M_RUN && src == pm_clock_pkg::SRC_PRI) |-> o_flags.primary_running_flag)
      else $error("primary flag clear in primary run");
   sec_defer_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ12]
      (mode == pm_clock_pkg::M_RUN && !secondary_osc_enable)
      |=> !(mode == pm_clock_pkg::M_SWITCH && tgt == pm_clock_pkg::SRC_SEC))
      else $error("secondary entry not deferred");
   sleep_osc_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ18]
      (mode == pm_clock_pkg::M_SLEEP) |-> (o_flags == 3'h0 && !o_osc_en.pri))
      else $error("sleep left oscillator or flag on");
   freq_write_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n) // [RQ15]
      (wr_fire && awaddr_q == pm_clock_pkg::ADDR_CTRL && wstrb0_q)
      |=> (o_int_freq == $past(wdata_q[6:4])))
      else $error("frequency write not applied");
endmodule

// File: logic/pm_clock_pkg.sv
// Shared constants, types and carriers for the power mode clock switch
package pm_clock_pkg;
   // AXI4-Lite register map, byte addresses
   localparam int AXI_AW = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_SECT = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Control register fields
   localparam int CTRL_IDLE_BIT = 7;
   localparam int CTRL_FREQ_LSB = 4;
   localparam int CTRL_PRI_BIT = 3;
   localparam int CTRL_HF_BIT = 2;
   localparam int CTRL_SEL_LSB = 0;
   // Secondary control register fields
   localparam int SECT_EN_BIT = 0;
   localparam int SECT_RUN_BIT = 1;
   // Status register fields
   localparam int STAT_FLAGS_LSB = 0;
   localparam int STAT_MODE_LSB = 3;
   localparam int STAT_SRC_LSB = 6;
   // Reset values
   localparam logic RST_IDLE = 1'h0;
   localparam logic [2:0] RST_FREQ = 3'h3;
   localparam logic [1:0] RST_SEL = 2'h0;
   localparam logic RST_SEC_EN = 1'h0;
   // Handover length, in half cycles of each source, rounded up to whole ticks
   localparam int SWITCH_OLD_HALF = 5;
   localparam int SWITCH_NEW_HALF = 5;
   localparam logic [1:0] OLD_TICKS = 2'((SWITCH_OLD_HALF + 1) / 2);
   localparam logic [1:0] NEW_TICKS = 2'((SWITCH_NEW_HALF + 1) / 2);

   typedef enum logic [2:0] {
      M_RUN = 3'b000,
      M_SWITCH = 3'b001,
      M_IDLE = 3'b010,
      M_SLEEP = 3'b011,
      M_WAKE = 3'b100
   } mode_t;

   typedef enum logic [1:0] {
      SRC_PRI = 2'b00,
      SRC_SEC = 2'b01,
      SRC_INT = 2'b10
   } src_t;

   typedef enum logic [1:0] {
      P_START = 2'b00,
      P_OLD = 2'b01,
      P_NEW = 2'b10
   } phase_t;

   typedef struct packed {
      logic pri_is_internal;
      logic two_speed;
      logic fail_safe;
      logic wdt_on;
   } cfg_t;

   typedef struct packed {
      logic pri;
      logic sec;
      logic hf;
      logic lf;
   } osc_en_t;

   typedef struct packed {
      logic primary_running_flag;
      logic internal_hf_stable_flag;
      logic secondary_active_flag;
   } flags_t;
endpackage

// File: verif/osc_model.sv
// Behavioural oscillators: gated ticks and start-up ready levels
`timescale 1ns/1ps
module osc_model (
   // Enables from the switch
   input wire pm_clock_pkg::osc_en_t i_en,
   // Oscillator pins
   output logic [2:0] o_tick,
   output logic [2:0] o_ready
);
   logic [2:0] on;
   int age [3];
   assign on = {i_en.hf | i_en.lf, i_en.sec, i_en.pri};
   initial o_tick = 3'h0;
   initial o_ready = 3'h0;
   // Stopped oscillators park low, never frozen mid-phase
   always #200 o_tick[0] = on[0] & ~o_tick[0];
   always #500 o_tick[1] = on[1] & ~o_tick[1];
   always #150 o_tick[2] = on[2] & ~o_tick[2];
   // Start-up time: ready after 2 us, lost at once when disabled
   always #100 begin
      for (int i = 0; i < 3; i++) begin
         age[i] = on[i] ? age[i] + 1 : 0;
         o_ready[i] = age[i] >= 20;
      end
   end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the power mode clock switch
`timescale 1ns/1ps
module testbench;
   logic clk = 0, rst_b = 0, slp = 0, wk = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic awready, wready, bvalid, arready, rvalid, core, per;
   logic [1:0] bresp, rresp;
   logic [2:0] tick, rdy, freq;
   pm_clock_pkg::osc_en_t oen;
   pm_clock_pkg::flags_t fl;
   int failures = 0, comparisons = 0, nc, np;
   pm_clock_pkg::cfg_t cfg = '0;
   initial forever #25 clk = ~clk;
   osc_model i_osc_model (.i_en(oen), .o_tick(tick), .o_ready(rdy));
   power_mode_clock_switch i_power_mode_clock_switch (.i_ref_clk(clk), .i_rst_b(rst_b), .i_osc_tick(tick),
      .i_osc_ready(rdy), .i_cfg(cfg), .i_sleep_req(slp), .i_wake(wk), .o_core_clk_en(core),
      .o_periph_clk_en(per), .o_osc_en(oen), .o_flags(fl), .o_int_freq(freq), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready));
   task tally_and_finish;
      $display("Counts: failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task timeout;
      failures++;
      tally_and_finish();
   endtask
   // Handshakes judged at the falling edge, where registered outputs are settled
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic pa, pw, aw, w, b;
      pa = 1;
      pw = 1;
      b = 0;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      for (int n = 0; n < 60 && !b; n++) begin
         @(negedge clk);
         {aw, w, b} = {awready & pa, wready & pw, bvalid};
         @(posedge clk);
         if (aw) {awvalid, pa} <= 2'h0;
         if (w) {wvalid, pw} <= 2'h0;
      end
      bready <= 0;
      if (!b) timeout();
      check({30'h0, bresp}, 32'h0000_0000);
   endtask
   task rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic pa, r;
      pa = 1;
      r = 0;
      @(posedge clk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      for (int n = 0; n < 60 && !r; n++) begin
         @(negedge clk);
         r = rvalid;
         if (!r && arready && pa) begin
            @(posedge clk);
            {arvalid, pa} <= 2'h0;
         end else @(posedge clk);
      end
      rready <= 0;
      if (!r) timeout();
      check(rdata, exp);
      check({30'h0, rresp}, {30'h0, er});
   endtask
   task wait_fl(input logic [2:0] e);
      for (int n = 0; n < 2000 && fl !== e; n++) @(negedge clk);
      check({29'h0, fl}, {29'h0, e});
      if (fl !== e) tally_and_finish();
   endtask
   task pulses(input int cyc);
      nc = 0;
      np = 0;
      repeat (cyc) begin
         @(negedge clk);
         nc += core;
         np += per;
      end
   endtask
   task kick(input bit w);
      @(posedge clk);
      if (w) wk <= 1;
      else slp <= 1;
      @(posedge clk);
      {wk, slp} <= 2'h0;
      repeat (3) @(posedge clk);
   endtask
   task t_reset;
      check({29'h0, fl}, 32'h0000_0004);
      rd_chk(4'h0, 32'h0000_0038, 2'h0);
      rd_chk(4'hc, 32'h0000_0000, pm_clock_pkg::RESP_SLVERR);
      pulses(40);
      check(32'(nc > 0 && np > 0), 32'h0000_0001);
   endtask
   task t_secondary;
      wr(4'h0, 32'h0000_0031);
      repeat (100) @(posedge clk);
      check({29'h0, fl}, 32'h0000_0004);
      wr(4'h4, 32'h0000_0001);
      wait_fl(3'h1);
      check({30'h0, oen.pri, oen.sec}, 32'h0000_0001);
      wr(4'h0, 32'h0000_0030);
      check({29'h0, fl}, 32'h0000_0001);
      wait_fl(3'h4);
      check({31'h0, oen.sec}, 32'h0000_0001);
   endtask
   task t_internal;
      wr(4'h0, 32'h0000_0032);
      wait_fl(3'h2);
      check({31'h0, oen.pri}, 32'h0000_0000);
      check({31'h0, oen.hf}, 32'h0000_0001);
      wr(4'h0, 32'h0000_0052);
      check({29'h0, freq}, 32'h0000_0005);
      wr(4'h0, 32'h0000_0030);
      wait_fl(3'h4);
   endtask
   task t_idle;
      wr(4'h0, 32'h0000_00b0);
      kick(0);
      pulses(40);
      check({27'h0, nc == 0, np > 0, fl}, 32'h0000_001c);
      kick(1);
      pulses(40);
      check(32'(nc > 0), 32'h0000_0001);
   endtask
   task t_deep;
      wr(4'h0, 32'h0000_0030);
      kick(0);
      pulses(40);
      check(nc, 32'h0000_0000);
      check(np, 32'h0000_0000);
      check({fl, oen.pri, oen.sec}, 32'h0000_0001);
      kick(1);
      pulses(20);
      check(nc + np, 32'h0000_0000);
      wait_fl(3'h4);
      rd_chk(4'h0, 32'h0000_0038, 2'h0);
   endtask
   // Internal primary, two-speed wake and watchdog oscillator
   task t_cfg;
      @(posedge clk);
      cfg <= 4'hd;
      wait_fl(3'h6);
      kick(0);
      check({25'h0, fl, oen}, 32'h0000_0005);
      kick(1);
      pulses(20);
      check(32'(nc > 0), 32'h0000_0001);
      wait_fl(3'h6);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1;
      repeat (6) @(posedge clk);
      t_reset();
      t_secondary();
      t_internal();
      t_idle();
      t_deep();
      t_cfg();
      tally_and_finish();
   end
endmodule
